// ===== logic/dspcs_map.svh
// Offsets, field positions, reset values and codes of the extension state.
`ifndef DSPCS_MAP_SVH
`define DSPCS_MAP_SVH
`define DSPCS_RESERVED_MSB 31
`define DSPCS_RESERVED_LSB 28
`define DSPCS_COND_MSB 27
`define DSPCS_COND_LSB 24
`define DSPCS_OVF_MSB 23
`define DSPCS_OVF_LSB 16
`define DSPCS_OVF_ACC_BASE 16
`define DSPCS_OVF_ADD 20
`define DSPCS_OVF_MUL 21
`define DSPCS_OVF_SHIFT 22
`define DSPCS_OVF_EXTRACT 23
`define DSPCS_EXTRACT_FAIL 14
`define DSPCS_CARRY 13
`define DSPCS_SIZE_MSB 12
`define DSPCS_SIZE_LSB 7
`define DSPCS_POS_MSB 5
`define DSPCS_POS_LSB 0
`define DSPCS_WRITE_MASK 32'h0FFF_7FBF
`define DSPCS_RESET 32'h0000_0000
`define DSPCS_POS_STEP 6'h20
`define DSPCS_DISABLED_CAUSE 5'h1A
`define DSPCS_ACC_RESET 32'h0000_0000
`endif

// ===== logic/dspcs_pkg.sv
// Types shared by the extension state files.
package dspcs_pkg;
   typedef enum logic [3:0] {
      DSPCS_OP_NONE = 4'h0,
      DSPCS_OP_WRITE_CTRL = 4'h1,
      DSPCS_OP_COMPARE = 4'h2,
      DSPCS_OP_ARITH = 4'h3,
      DSPCS_OP_ADD_CARRY_OUT = 4'h4,
      DSPCS_OP_ADD_CARRY_IN = 4'h5,
      DSPCS_OP_POS_EXTRACT = 4'h6,
      DSPCS_OP_POS_EXTRACT_DEC = 4'h7,
      DSPCS_OP_LOW_TO_HIGH = 4'h8,
      DSPCS_OP_ACC_WRITE = 4'h9,
      DSPCS_OP_ACC_READ = 4'hA,
      DSPCS_OP_INSERT = 4'hB
   } dspcs_op_t;
   typedef enum logic [1:0] {
      DSPCS_OVC_NONE = 2'h0,
      DSPCS_OVC_ADD = 2'h1,
      DSPCS_OVC_MUL = 2'h2,
      DSPCS_OVC_SHIFT = 2'h3
   } dspcs_ovf_class_t;
endpackage

// ===== logic/dspcs_acc_bank.sv
// Four high/low accumulator pairs selected by a two-bit index.
`include "dspcs_map.svh"
module dspcs_acc_bank #(
   parameter int WIDTH = 32,
   parameter int PAIRS = 4
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic wr_en,
   input wire logic [1:0] wr_sel,
   input wire logic [WIDTH-1:0] wr_hi,
   input wire logic [WIDTH-1:0] wr_lo,
   input wire logic [1:0] rd_sel,
   output logic [WIDTH-1:0] rd_hi,
   output logic [WIDTH-1:0] rd_lo
);
   logic [WIDTH-1:0] hi_q [PAIRS];
   logic [WIDTH-1:0] lo_q [PAIRS];
   logic [WIDTH-1:0] hi_d [PAIRS];
   logic [WIDTH-1:0] lo_d [PAIRS];

   // Each pair loads only when the two-bit index names it.
   for (genvar i = 0; i < PAIRS; i++) begin : g_pair
      always_comb begin
         hi_d[i] = hi_q[i];
         lo_d[i] = lo_q[i];
         if (wr_en && (wr_sel == 2'(i))) begin
            hi_d[i] = wr_hi;
            lo_d[i] = wr_lo;
         end
      end
      always_ff @(posedge ref_clk) begin
         if (srst) begin
            hi_q[i] <= WIDTH'(`DSPCS_ACC_RESET);
            lo_q[i] <= WIDTH'(`DSPCS_ACC_RESET);
         end else begin
            hi_q[i] <= hi_d[i];
            lo_q[i] <= lo_d[i];
         end
      end
   end

   assign rd_hi = hi_q[rd_sel];
   assign rd_lo = lo_q[rd_sel];
endmodule

// ===== logic/dspcs_state.sv
// Signal-processing extension state: accumulators and control/status register.
// Operation
// - Four accumulator pairs, two-bit destination select.
// - Reserved control bits always read zero.
// - Compare writes low condition bits only.
// - Overflow flags sticky until control write.
// - Accumulator overflow sets flag sixteen plus index.
// - Flags twenty to twenty-two by class, twenty-three by extract overflow.
// - Every position extract writes fail flag.
// - Carry written by carry-out, used by carry-in.
// - Variable insert takes size from size field.
// - Position field; decrementing extracts subtract extract size, position held when extract size exceeds it.
// - Low-to-high copy adds thirty-two to position.
// - Disabled access raises exception, cause twenty-six.
// - Static revision, present and rev2 bits.
`include "dspcs_map.svh"
module dspcs_state #(
   parameter int WIDTH = 32,
   parameter logic [2:0] ARCH_REVISION = 3'h0,
   parameter logic PRESENT = 1'b1,
   parameter logic REV2_PRESENT = 1'b1
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic extension_access_enable,
   input wire logic op_valid,
   input wire dspcs_pkg::dspcs_op_t op_code,
   input wire logic [1:0] acc_sel,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic [WIDTH-1:0] wr_data_hi,
   input wire logic [3:0] cmp_result,
   input wire logic [2:0] cmp_count,
   input wire logic acc_overflow,
   input wire dspcs_pkg::dspcs_ovf_class_t ovf_class,
   input wire logic extract_overflow,
   input wire logic carry_in_value,
   input wire logic [5:0] extract_size,
   output logic [WIDTH-1:0] ctrl_rdata,
   output logic [WIDTH-1:0] acc_hi_rdata,
   output logic [WIDTH-1:0] acc_lo_rdata,
   output logic carry_for_add,
   output logic [5:0] insert_size,
   output logic [5:0] bit_position,
   output logic disabled_exc,
   output logic [4:0] exc_cause,
   output logic [2:0] arch_revision_bits,
   output logic extension_present_bit,
   output logic extension_rev2_present_bit
);
   logic [31:0] ctrl_q;
   logic [31:0] ctrl_d;
   logic [WIDTH-1:0] acc_hi_q;
   logic [WIDTH-1:0] acc_lo_q;
   logic [WIDTH-1:0] bank_hi;
   logic [WIDTH-1:0] bank_lo;
   logic exc_q;
   logic exc_d;
   logic [4:0] cause_q;
   logic [4:0] cause_d;
   logic [2:0] rev_q;
   logic pres_q;
   logic pres2_q;
   logic go;
   logic acc_wr;
   logic [WIDTH-1:0] acc_wr_hi;
   logic [WIDTH-1:0] acc_wr_lo;
   logic [5:0] pos;
   logic [5:0] size;

   assign pos = ctrl_q[`DSPCS_POS_MSB:`DSPCS_POS_LSB];
   assign size = ctrl_q[`DSPCS_SIZE_MSB:`DSPCS_SIZE_LSB];
   // Nothing executes while the extension is disabled.
   assign go = op_valid && extension_access_enable && (op_code != dspcs_pkg::DSPCS_OP_NONE);

   always_comb begin
      acc_wr = 1'b0;
      acc_wr_hi = bank_hi;
      acc_wr_lo = bank_lo;
      if (go && op_code == dspcs_pkg::DSPCS_OP_ACC_WRITE) begin
         acc_wr = 1'b1;
         acc_wr_hi = wr_data_hi;
         acc_wr_lo = wr_data;
      end else if (go && op_code == dspcs_pkg::DSPCS_OP_LOW_TO_HIGH) begin
         acc_wr = 1'b1;
         acc_wr_hi = bank_lo;
         acc_wr_lo = wr_data;
      end
   end

   dspcs_acc_bank #(
      .WIDTH(WIDTH),
      .PAIRS(4)
   ) u_bank (
      .ref_clk(ref_clk),
      .srst(srst),
      .wr_en(acc_wr),
      .wr_sel(acc_sel),
      .wr_hi(acc_wr_hi),
      .wr_lo(acc_wr_lo),
      .rd_sel(acc_sel),
      .rd_hi(bank_hi),
      .rd_lo(bank_lo)
   );

   always_comb begin
      ctrl_d = ctrl_q;
      if (go) begin
         unique case (op_code)
            dspcs_pkg::DSPCS_OP_WRITE_CTRL: begin
               ctrl_d = wr_data[31:0] & `DSPCS_WRITE_MASK;
            end
            dspcs_pkg::DSPCS_OP_COMPARE: begin
               for (int i = 0; i < 4; i++) begin
                  if (i < int'(cmp_count)) begin
                     ctrl_d[`DSPCS_COND_LSB + i] = cmp_result[i];
                  end
               end
            end
            dspcs_pkg::DSPCS_OP_ARITH: begin
               if (acc_overflow) begin
                  ctrl_d[`DSPCS_OVF_ACC_BASE + int'(acc_sel)] = 1'b1;
               end
               unique case (ovf_class)
                  dspcs_pkg::DSPCS_OVC_ADD: ctrl_d[`DSPCS_OVF_ADD] = 1'b1;
                  dspcs_pkg::DSPCS_OVC_MUL: ctrl_d[`DSPCS_OVF_MUL] = 1'b1;
                  dspcs_pkg::DSPCS_OVC_SHIFT: ctrl_d[`DSPCS_OVF_SHIFT] = 1'b1;
                  dspcs_pkg::DSPCS_OVC_NONE: ;
               endcase
               if (extract_overflow) begin
                  ctrl_d[`DSPCS_OVF_EXTRACT] = 1'b1;
               end
            end
            dspcs_pkg::DSPCS_OP_ADD_CARRY_OUT: begin
               ctrl_d[`DSPCS_CARRY] = carry_in_value;
            end
            dspcs_pkg::DSPCS_OP_ADD_CARRY_IN: begin
               if (ovf_class == dspcs_pkg::DSPCS_OVC_ADD) begin
                  ctrl_d[`DSPCS_OVF_ADD] = 1'b1;
               end
            end
            dspcs_pkg::DSPCS_OP_POS_EXTRACT: begin
               ctrl_d[`DSPCS_EXTRACT_FAIL] = (pos < extract_size);
            end
            dspcs_pkg::DSPCS_OP_POS_EXTRACT_DEC: begin
               ctrl_d[`DSPCS_EXTRACT_FAIL] = (pos < extract_size);
               if (pos >= extract_size) begin
                  ctrl_d[`DSPCS_POS_MSB:`DSPCS_POS_LSB] = pos - extract_size;
               end
            end
            dspcs_pkg::DSPCS_OP_LOW_TO_HIGH: begin
               ctrl_d[`DSPCS_POS_MSB:`DSPCS_POS_LSB] = pos + `DSPCS_POS_STEP;
            end
            default: ;
         endcase
      end
   end

   always_comb begin
      exc_d = op_valid && !extension_access_enable
         && (op_code != dspcs_pkg::DSPCS_OP_NONE);
      cause_d = exc_d ? `DSPCS_DISABLED_CAUSE : 5'h00;
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ctrl_q <= `DSPCS_RESET;
         exc_q <= 1'b0;
         cause_q <= 5'h00;
         acc_hi_q <= WIDTH'(`DSPCS_ACC_RESET);
         acc_lo_q <= WIDTH'(`DSPCS_ACC_RESET);
         rev_q <= 3'h0;
         pres_q <= 1'b0;
         pres2_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         exc_q <= exc_d;
         cause_q <= cause_d;
         acc_hi_q <= bank_hi;
         acc_lo_q <= bank_lo;
         rev_q <= ARCH_REVISION;
         pres_q <= PRESENT;
         pres2_q <= REV2_PRESENT;
      end
   end

   // Register copies keep every output straight from a flip-flop.
   assign ctrl_rdata = WIDTH'(ctrl_q);
   assign acc_hi_rdata = acc_hi_q;
   assign acc_lo_rdata = acc_lo_q;
   assign carry_for_add = ctrl_q[`DSPCS_CARRY];
   assign insert_size = size;
   assign bit_position = pos;
   assign disabled_exc = exc_q;
   assign exc_cause = cause_q;
   assign arch_revision_bits = rev_q;
   assign extension_present_bit = pres_q;
   assign extension_rev2_present_bit = pres2_q;

   reserved_zero_a: assert property (@(posedge ref_clk) disable iff (srst)
      ctrl_q[31:28] == 4'h0 && ctrl_q[15] == 1'b0 && ctrl_q[6] == 1'b0)
      else $error("Reserved control bits not zero.");
   ovf_sticky_a: assert property (@(posedge ref_clk) disable iff (srst)
      (|ctrl_q[23:16]) && !(go && op_code == dspcs_pkg::DSPCS_OP_WRITE_CTRL)
      |=> ((ctrl_q[23:16] & $past(ctrl_q[23:16])) == $past(ctrl_q[23:16])))
      else $error("Overflow flag cleared without control write.");
   acc_ovf_a: assert property (@(posedge ref_clk) disable iff (srst)
      go && op_code == dspcs_pkg::DSPCS_OP_ARITH && acc_overflow
      |=> ctrl_q[16 + int'($past(acc_sel))])
      else $error("Accumulator overflow flag not set.");
   extract_fail_a: assert property (@(posedge ref_clk) disable iff (srst)
      go && op_code == dspcs_pkg::DSPCS_OP_POS_EXTRACT
      |=> ctrl_q[14] == ($past(pos) < $past(extract_size)))
      else $error("Extract fail flag wrong.");
   carry_a: assert property (@(posedge ref_clk) disable iff (srst)
      go && op_code == dspcs_pkg::DSPCS_OP_ADD_CARRY_OUT
      |=> carry_for_add == $past(carry_in_value))
      else $error("Carry not written.");
   pos_step_a: assert property (@(posedge ref_clk) disable iff (srst)
      go && op_code == dspcs_pkg::DSPCS_OP_LOW_TO_HIGH
      |=> bit_position == 6'($past(pos) + 6'h20))
      else $error("Position not advanced by 32.");
   disabled_exc_a: assert property (@(posedge ref_clk) disable iff (srst)
      op_valid && !extension_access_enable && op_code != dspcs_pkg::DSPCS_OP_NONE
      |=> disabled_exc && exc_cause == 5'h1A && ctrl_q == $past(ctrl_q))
      else $error("Disabled access not trapped.");
   cond_write_a: assert property (@(posedge ref_clk) disable iff (srst)
      go && op_code == dspcs_pkg::DSPCS_OP_COMPARE && cmp_count == 3'h2
      |=> ctrl_q[25:24] == $past(cmp_result[1:0])
         && ctrl_q[27:26] == $past(ctrl_q[27:26]))
      else $error("Condition bits not written as counted.");
   ovf_class_a: assert property (@(posedge ref_clk) disable iff (srst)
      go && op_code == dspcs_pkg::DSPCS_OP_ARITH && ovf_class != dspcs_pkg::DSPCS_OVC_NONE
      |=> ctrl_q[`DSPCS_OVF_ADD - 1 + int'($past(ovf_class))])
      else $error("Class overflow flag not set.");
   extract_ovf_a: assert property (@(posedge ref_clk) disable iff (srst)
      go && op_code == dspcs_pkg::DSPCS_OP_ARITH && extract_overflow
      |=> ctrl_q[`DSPCS_OVF_EXTRACT])
      else $error("Extract overflow flag not set.");
   pos_dec_a: assert property (@(posedge ref_clk) disable iff (srst)
      go && op_code == dspcs_pkg::DSPCS_OP_POS_EXTRACT_DEC && pos >= extract_size
      |=> bit_position == 6'($past(pos) - $past(extract_size)))
      else $error("Position not reduced by extract size.");
   static_bits_a: assert property (@(posedge ref_clk) disable iff (srst)
      !srst |=> arch_revision_bits == ARCH_REVISION && extension_present_bit == PRESENT
         && extension_rev2_present_bit == REV2_PRESENT)
      else $error("Static configuration bits wrong.");
   exc_idle_a: assert property (@(posedge ref_clk) disable iff (srst)
      !(op_valid && !extension_access_enable && op_code != dspcs_pkg::DSPCS_OP_NONE)
      |=> !disabled_exc && exc_cause == 5'h00)
      else $error("Exception raised without disabled access.");
   reset_zero_a: assert property (@(posedge ref_clk)
      srst |=> ctrl_q == 32'h0000_0000)
      else $error("Control register not zero after reset.");
   cover_exc_c: cover property (@(posedge ref_clk) disable iff (srst) disabled_exc);
   cover_fail_c: cover property (@(posedge ref_clk) disable iff (srst) ctrl_q[14]);
   cover_ovf_c: cover property (@(posedge ref_clk) disable iff (srst) &ctrl_q[19:16]);
   cover_carry_c: cover property (@(posedge ref_clk) disable iff (srst) carry_for_add);
   cover_cond_c: cover property (@(posedge ref_clk) disable iff (srst)
      go && op_code == dspcs_pkg::DSPCS_OP_COMPARE);
endmodule

// ===== tb/dspcs_state_test.sv
// Self-checking bench for the extension state block.
module dspcs_state_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic enable = 1'b1;
   logic op_valid = 1'b0;
   dspcs_pkg::dspcs_op_t op_code = dspcs_pkg::DSPCS_OP_NONE;
   logic [1:0] acc_sel = 2'h0;
   logic [31:0] wr_data = 32'h0000_0000;
   logic [31:0] wr_data_hi = 32'h0000_0000;
   logic [3:0] cmp_result = 4'h0;
   logic [2:0] elem_count = 3'h0;
   logic acc_overflow = 1'b0;
   dspcs_pkg::dspcs_ovf_class_t ovf_class = dspcs_pkg::DSPCS_OVC_NONE;
   logic extract_overflow = 1'b0;
   logic carry_in_value = 1'b0;
   logic [5:0] extract_size = 6'h00;
   logic [31:0] ctrl_rdata;
   logic [31:0] acc_hi_rdata;
   logic [31:0] acc_lo_rdata;
   logic carry_for_add;
   logic [5:0] insert_size;
   logic [5:0] bit_position;
   logic disabled_exc;
   logic [4:0] exc_cause;
   logic [2:0] arch_revision_bits;
   logic extension_present_bit;
   logic extension_rev2_present_bit;
   int err_count = 0;
   int cmp_count = 0;
   int cycles = 0;

   dspcs_state dspcs_state_i (
      .ref_clk(ref_clk), .srst(srst), .extension_access_enable(enable),
      .op_valid(op_valid), .op_code(op_code), .acc_sel(acc_sel), .wr_data(wr_data),
      .wr_data_hi(wr_data_hi), .cmp_result(cmp_result), .cmp_count(elem_count),
      .acc_overflow(acc_overflow), .ovf_class(ovf_class),
      .extract_overflow(extract_overflow), .carry_in_value(carry_in_value),
      .extract_size(extract_size), .ctrl_rdata(ctrl_rdata), .acc_hi_rdata(acc_hi_rdata),
      .acc_lo_rdata(acc_lo_rdata), .carry_for_add(carry_for_add),
      .insert_size(insert_size), .bit_position(bit_position),
      .disabled_exc(disabled_exc), .exc_cause(exc_cause),
      .arch_revision_bits(arch_revision_bits),
      .extension_present_bit(extension_present_bit),
      .extension_rev2_present_bit(extension_rev2_present_bit)
   );

   initial begin
      forever #10 ref_clk = ~ref_clk;
   end

   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         err_count++;
         conclude();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   // Issues one operation at a falling edge and holds it until the next call or idle.
   task automatic op(input dspcs_pkg::dspcs_op_t c, input logic [1:0] s, input logic [31:0] d);
      op_valid = 1'b1;
      op_code = c;
      acc_sel = s;
      wr_data = d;
      @(negedge ref_clk);
   endtask

   // Ends a run of operations and lets one clock edge pass with nothing issued.
   task automatic idle();
      op_valid = 1'b0;
      op_code = dspcs_pkg::DSPCS_OP_NONE;
      @(negedge ref_clk);
   endtask

   initial begin
      repeat (10) @(negedge ref_clk);
      srst = 1'b0;
      @(negedge ref_clk);
      chk(ctrl_rdata, 32'h0000_0000);
      chk({arch_revision_bits, extension_present_bit, extension_rev2_present_bit}, 5'h03);
      op(dspcs_pkg::DSPCS_OP_WRITE_CTRL, 2'h0, 32'hFFFF_FFFF);
      chk(ctrl_rdata, 32'h0FFF_7FBF);
      chk({carry_for_add, insert_size, bit_position}, 13'h1FFF);
      op(dspcs_pkg::DSPCS_OP_WRITE_CTRL, 2'h0, 32'h0F00_0A80);
      chk(insert_size, 6'h15);
      cmp_result = 4'h0;
      elem_count = 3'h2;
      op(dspcs_pkg::DSPCS_OP_COMPARE, 2'h0, 32'h0000_0000);
      chk(ctrl_rdata, 32'h0C00_0A80);
      op(dspcs_pkg::DSPCS_OP_WRITE_CTRL, 2'h0, 32'h0000_0000);
      acc_overflow = 1'b1;
      op(dspcs_pkg::DSPCS_OP_ARITH, 2'h3, 32'h0000_0000);
      chk(ctrl_rdata, 32'h0008_0000);
      acc_overflow = 1'b0;
      for (int k = 1; k < 4; k++) begin
         ovf_class = dspcs_pkg::dspcs_ovf_class_t'(k);
         op(dspcs_pkg::DSPCS_OP_ARITH, 2'h0, 32'h0000_0000);
         chk(ctrl_rdata[23:16], 8'h08 | ((8'h10 << k) - 8'h10));
      end
      ovf_class = dspcs_pkg::DSPCS_OVC_NONE;
      extract_overflow = 1'b1;
      op(dspcs_pkg::DSPCS_OP_ARITH, 2'h1, 32'h0000_0000);
      extract_overflow = 1'b0;
      op(dspcs_pkg::DSPCS_OP_ARITH, 2'h1, 32'h0000_0000);
      chk(ctrl_rdata, 32'h00F8_0000);
      op(dspcs_pkg::DSPCS_OP_WRITE_CTRL, 2'h0, 32'h0000_000A);
      chk(ctrl_rdata, 32'h0000_000A);
      extract_size = 6'h0B;
      op(dspcs_pkg::DSPCS_OP_POS_EXTRACT, 2'h0, 32'h0000_0000);
      chk(ctrl_rdata, 32'h0000_400A);
      extract_size = 6'h0A;
      op(dspcs_pkg::DSPCS_OP_POS_EXTRACT, 2'h0, 32'h0000_0000);
      chk(ctrl_rdata, 32'h0000_000A);
      extract_size = 6'h04;
      op(dspcs_pkg::DSPCS_OP_POS_EXTRACT_DEC, 2'h0, 32'h0000_0000);
      chk(bit_position, 6'h06);
      wr_data_hi = 32'hAAAA_AAAA;
      op(dspcs_pkg::DSPCS_OP_ACC_WRITE, 2'h1, 32'hBBBB_BBBB);
      wr_data_hi = 32'h1111_1111;
      op(dspcs_pkg::DSPCS_OP_ACC_WRITE, 2'h2, 32'h2222_2222);
      op(dspcs_pkg::DSPCS_OP_LOW_TO_HIGH, 2'h2, 32'h3333_3333);
      chk(bit_position, 6'h26);
      idle();
      chk(acc_hi_rdata, 32'h2222_2222);
      chk(acc_lo_rdata, 32'h3333_3333);
      acc_sel = 2'h1;
      @(negedge ref_clk);
      chk(acc_hi_rdata, 32'hAAAA_AAAA);
      chk(acc_lo_rdata, 32'hBBBB_BBBB);
      carry_in_value = 1'b1;
      op(dspcs_pkg::DSPCS_OP_ADD_CARRY_OUT, 2'h0, 32'h0000_0000);
      chk({carry_for_add, ctrl_rdata[13]}, 2'h3);
      carry_in_value = 1'b0;
      op(dspcs_pkg::DSPCS_OP_ADD_CARRY_OUT, 2'h0, 32'h0000_0000);
      chk({carry_for_add, ctrl_rdata[13]}, 2'h0);
      ovf_class = dspcs_pkg::DSPCS_OVC_ADD;
      op(dspcs_pkg::DSPCS_OP_ADD_CARRY_IN, 2'h0, 32'h0000_0000);
      chk(ctrl_rdata[23:16], 8'h10);
      ovf_class = dspcs_pkg::DSPCS_OVC_NONE;
      enable = 1'b0;
      op(dspcs_pkg::DSPCS_OP_WRITE_CTRL, 2'h0, 32'hFFFF_FFFF);
      chk({disabled_exc, exc_cause}, 6'h3A);
      chk(ctrl_rdata, 32'h0010_0026);
      idle();
      chk({disabled_exc, exc_cause}, 6'h00);
      enable = 1'b1;
      srst = 1'b1;
      @(negedge ref_clk);
      chk({arch_revision_bits, extension_present_bit, extension_rev2_present_bit}, 5'h00);
      srst = 1'b0;
      chk(ctrl_rdata, 32'h0000_0000);
      @(negedge ref_clk);
      chk({arch_revision_bits, extension_present_bit, extension_rev2_present_bit}, 5'h03);
      chk(ctrl_rdata, 32'h0000_0000);
      conclude();
   end
endmodule
